// ---- lsir_consts.svh ----
// register indices, field positions, masks and reset values of the line status register group
`ifndef LSIR_CONSTS_SVH
`define LSIR_CONSTS_SVH

// register indices; byte address is index times four
`define LSIR_IDX_TX_JIT_CTRL  8'h21
`define LSIR_IDX_RX_JIT_CTRL  8'h27
`define LSIR_IDX_EV0_ENABLE   8'h33
`define LSIR_IDX_EV1_ENABLE   8'h34
`define LSIR_IDX_EDGE_SELECT  8'h35
`define LSIR_IDX_LINE_STATUS  8'h36
`define LSIR_IDX_LINE_GAIN    8'h37
`define LSIR_IDX_TX_JITTER    8'h38
`define LSIR_IDX_RX_JITTER    8'h39
`define LSIR_IDX_LINE_EVENT   8'h3a
`define LSIR_IDX_ERROR_EVENT  8'h3b
`define LSIR_IDX_COUNT_HIGH   8'h3c
`define LSIR_IDX_COUNT_LOW    8'h3d
`define LSIR_IDX_REF_CONTROL  8'h3e
`define LSIR_IDX_LINE_UNIT    8'h3f
`define LSIR_IDX_FUNCTION     8'h40

// field positions
`define LSIR_BIT_JIT_TEST     5
`define LSIR_BIT_DRV_FAULT    2
`define LSIR_BIT_SIG_LOSS     0
`define LSIR_BIT_TEMPLATE     6
`define LSIR_BIT_TX_SLIP      5
`define LSIR_BIT_RX_SLIP      4
`define LSIR_BIT_ZERO_RUN     2
`define LSIR_BIT_CODE_VIOL    1
`define LSIR_BIT_CNT_OVF      0
`define LSIR_BIT_REF_HOLD     0

// writable bits of each register
`define LSIR_MASK_LINE        8'h05
`define LSIR_MASK_ERROR       8'h77
`define LSIR_MASK_JIT_CTRL    8'h20
`define LSIR_MASK_REF         8'h01

// reset values and limits
`define LSIR_RST_BYTE         8'h00
`define LSIR_RST_COUNT        16'h0000
`define LSIR_COUNT_MAX        16'hffff
`define LSIR_RST_JIT          7'h00
`define LSIR_GAIN_TOP         5'h15

`endif

// ---- lsir_pkg.sv ----
// types shared by the line status register group
package lsir_pkg;

    // one-cycle error pulses from the line logic, same clock
    typedef struct packed {
        logic template_overflow;
        logic tx_fifo_slip;
        logic rx_fifo_slip;
        logic zero_run_err;
        logic code_violation;
    } lsir_err_pulse_t;

    // jitter fifo pointer spacing per direction
    typedef struct packed {
        logic [6:0] tx_spacing;
        logic [6:0] rx_spacing;
    } lsir_spacing_t;

    // pending flags of the other function blocks, bit 7 first
    typedef struct packed {
        logic loopback_code_detector_pending;
        logic bit_message_receiver_pending;
        logic alarm_detector_pending;
        logic performance_monitor_pending;
        logic prbs_unit_pending;
        logic signalling_buffer_pending;
        logic frame_generator_pending;
        logic frame_processor_pending;
    } lsir_ind_t;

    typedef enum logic {LSIR_BUS_IDLE, LSIR_BUS_ACK} lsir_bus_state_t;

endpackage

// ---- lsir_regs.sv ----
// line status, event and indication registers behind an avalon-mm slave
`timescale 1ns/100ps
`include "lsir_consts.svh"

module lsir_regs (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [9:0]               avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    input  wire logic                     signal_loss_in,
    input  wire logic                     driver_fault_in,
    input  wire logic [4:0]               line_gain_in,
    input  wire lsir_pkg::lsir_spacing_t  spacing_in,
    input  wire lsir_pkg::lsir_err_pulse_t err_in,
    input  wire logic                     line_sub_irq_in,
    input  wire lsir_pkg::lsir_ind_t      ind_in,
    input  wire logic                     recovered_ref_in,
    output logic                          reference_clock_output,
    output logic                          irq
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_s1_r;
    logic rst_sync_n;

    // async assert, two-flop release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_r   <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end

    // ************************************************************
    // avalon slave
    // ************************************************************
    lsir_pkg::lsir_bus_state_t bus_st_r;
    logic        wait_r;
    logic [7:0]  rdata_r;
    logic        wr_acc;
    logic        rd_acc;
    logic [7:0]  wdat;
    logic [7:0]  rd_mux;

    // index hit: word aligned and matching index
    function automatic logic lsir_hit(input logic [9:0] a, input logic [7:0] idx);
        lsir_hit = (a[1:0] == 2'h0) && (a[9:2] == idx);
    endfunction

    assign wr_acc = avs_write && !wait_r;
    assign rd_acc = avs_read && !wait_r;
    assign wdat   = avs_writedata[7:0];

    // one wait cycle, then one cycle with waitrequest low
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_st_r <= lsir_pkg::LSIR_BUS_IDLE;
            wait_r   <= 1'b1;
            rdata_r  <= `LSIR_RST_BYTE;
        end else begin
            case (bus_st_r)
                lsir_pkg::LSIR_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_st_r <= lsir_pkg::LSIR_BUS_ACK;
                        wait_r   <= 1'b0;
                        rdata_r  <= rd_mux;
                    end
                end
                lsir_pkg::LSIR_BUS_ACK: begin
                    bus_st_r <= lsir_pkg::LSIR_BUS_IDLE;
                    wait_r   <= 1'b1;
                end
                default: begin
                    bus_st_r <= lsir_pkg::LSIR_BUS_IDLE;
                    wait_r   <= 1'b1;
                end
            endcase
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = {24'h000000, rdata_r};

    // ************************************************************
    // control registers
    // ************************************************************
    logic [7:0] jit_ctrl_r [2];
    logic [7:0] en0_r;
    logic [7:0] en1_r;
    logic [7:0] edge_r;
    logic [7:0] ref_ctrl_r;

    // plain read/write control bits
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            jit_ctrl_r[0] <= `LSIR_RST_BYTE;
            jit_ctrl_r[1] <= `LSIR_RST_BYTE;
            en0_r         <= `LSIR_RST_BYTE;
            en1_r         <= `LSIR_RST_BYTE;
            edge_r        <= `LSIR_RST_BYTE;
            ref_ctrl_r    <= `LSIR_RST_BYTE;
        end else if (wr_acc) begin
            if (lsir_hit(avs_address, `LSIR_IDX_TX_JIT_CTRL)) jit_ctrl_r[0] <= wdat & `LSIR_MASK_JIT_CTRL;
            if (lsir_hit(avs_address, `LSIR_IDX_RX_JIT_CTRL)) jit_ctrl_r[1] <= wdat & `LSIR_MASK_JIT_CTRL;
            if (lsir_hit(avs_address, `LSIR_IDX_EV0_ENABLE))  en0_r         <= wdat & `LSIR_MASK_LINE;
            if (lsir_hit(avs_address, `LSIR_IDX_EV1_ENABLE))  en1_r         <= wdat & `LSIR_MASK_ERROR;
            if (lsir_hit(avs_address, `LSIR_IDX_EDGE_SELECT)) edge_r        <= wdat & `LSIR_MASK_LINE;
            if (lsir_hit(avs_address, `LSIR_IDX_REF_CONTROL)) ref_ctrl_r    <= wdat & `LSIR_MASK_REF;
        end
    end

    // ************************************************************
    // status inputs from the analog side
    // ************************************************************
    logic [1:0] st_s1_r;
    logic [1:0] st_s2_r;
    logic [1:0] st_s3_r;
    logic [1:0] st_r;
    logic [1:0] st_prev_r;
    logic       los_st;
    logic       df_st;

    // three-flop sampling; change accepted when 2nd and 3rd agree
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_s1_r   <= 2'h0;
            st_s2_r   <= 2'h0;
            st_s3_r   <= 2'h0;
            st_r      <= 2'h0;
            st_prev_r <= 2'h0;
        end else begin
            st_s1_r   <= {driver_fault_in, signal_loss_in};
            st_s2_r   <= st_s1_r;
            st_s3_r   <= st_s2_r;
            st_prev_r <= st_r;
            for (int i = 0; i < 2; i++) begin
                if (st_s2_r[i] == st_s3_r[i]) st_r[i] <= st_s3_r[i];
            end
        end
    end

    assign los_st = st_r[0];
    assign df_st  = st_r[1];

    // ************************************************************
    // event flags
    // ************************************************************
    logic [7:0] ev0_r;
    logic [7:0] ev1_r;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic [15:0] zcnt_r;
    logic        zcnt_wrap;

    // edge detection on the filtered status bits
    always_comb begin
        set0 = 8'h00;
        set0[`LSIR_BIT_SIG_LOSS]  = (los_st & ~st_prev_r[0]) |
                                    (edge_r[`LSIR_BIT_SIG_LOSS] & ~los_st & st_prev_r[0]);
        set0[`LSIR_BIT_DRV_FAULT] = (df_st & ~st_prev_r[1]) |
                                    (edge_r[`LSIR_BIT_DRV_FAULT] & ~df_st & st_prev_r[1]);
    end

    assign zcnt_wrap = err_in.zero_run_err && (zcnt_r == `LSIR_COUNT_MAX);

    // error pulses into their flag positions
    always_comb begin
        set1 = 8'h00;
        set1[`LSIR_BIT_TEMPLATE]  = err_in.template_overflow;
        set1[`LSIR_BIT_TX_SLIP]   = err_in.tx_fifo_slip;
        set1[`LSIR_BIT_RX_SLIP]   = err_in.rx_fifo_slip;
        set1[`LSIR_BIT_ZERO_RUN]  = err_in.zero_run_err;
        set1[`LSIR_BIT_CODE_VIOL] = err_in.code_violation;
        set1[`LSIR_BIT_CNT_OVF]   = zcnt_wrap;
    end

    assign clr0 = (wr_acc && lsir_hit(avs_address, `LSIR_IDX_LINE_EVENT))  ? wdat : 8'h00;
    assign clr1 = (wr_acc && lsir_hit(avs_address, `LSIR_IDX_ERROR_EVENT)) ? wdat : 8'h00;

    // write one clears, zero keeps, a new event wins over the clear
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ev0_r <= `LSIR_RST_BYTE;
            ev1_r <= `LSIR_RST_BYTE;
        end else begin
            ev0_r <= ((ev0_r & ~clr0) | set0) & `LSIR_MASK_LINE;
            ev1_r <= ((ev1_r & ~clr1) | set1) & `LSIR_MASK_ERROR;
        end
    end

    // 16-bit excessive-zero counter, wraps to zero
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            zcnt_r <= `LSIR_RST_COUNT;
        end else if (err_in.zero_run_err) begin
            zcnt_r <= zcnt_r + 16'h0001;
        end
    end

    // ************************************************************
    // jitter measurement
    // ************************************************************
    logic [6:0] jit_min_r [2];
    logic [6:0] jit_max_r [2];
    logic [6:0] jit_val_r [2];
    logic [6:0] spc [2];
    logic       jit_clr [2];
    logic       jit_rd [2];

    assign spc[0]     = spacing_in.tx_spacing;
    assign spc[1]     = spacing_in.rx_spacing;
    assign jit_clr[0] = wr_acc && lsir_hit(avs_address, `LSIR_IDX_TX_JITTER) && (wdat != 8'h00);
    assign jit_clr[1] = wr_acc && lsir_hit(avs_address, `LSIR_IDX_RX_JITTER) && (wdat != 8'h00);
    assign jit_rd[0]  = rd_acc && lsir_hit(avs_address, `LSIR_IDX_TX_JITTER);
    assign jit_rd[1]  = rd_acc && lsir_hit(avs_address, `LSIR_IDX_RX_JITTER);

    // live spacing or peak-to-peak window restarted by a read
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int d = 0; d < 2; d++) begin
                jit_min_r[d] <= `LSIR_RST_JIT;
                jit_max_r[d] <= `LSIR_RST_JIT;
                jit_val_r[d] <= `LSIR_RST_JIT;
            end
        end else begin
            for (int d = 0; d < 2; d++) begin
                if (jit_rd[d] || jit_clr[d]) begin
                    jit_min_r[d] <= spc[d];
                    jit_max_r[d] <= spc[d];
                end else begin
                    if (spc[d] < jit_min_r[d]) jit_min_r[d] <= spc[d];
                    if (spc[d] > jit_max_r[d]) jit_max_r[d] <= spc[d];
                end
                if (jit_clr[d]) begin
                    jit_val_r[d] <= `LSIR_RST_JIT;
                end else if (!jit_ctrl_r[d][`LSIR_BIT_JIT_TEST]) begin
                    jit_val_r[d] <= spc[d];
                end else if (jit_rd[d]) begin
                    jit_val_r[d] <= `LSIR_RST_JIT;
                end else begin
                    jit_val_r[d] <= jit_max_r[d] - jit_min_r[d];
                end
            end
        end
    end

    // ************************************************************
    // gain, indications, reference clock and interrupt
    // ************************************************************
    logic [4:0] gain_r;
    logic       lu_r;
    logic [7:0] fn_r;
    logic       mclk_tog_r;
    logic       ref_r;
    logic       irq_r;
    logic       any_ev;

    assign any_ev = |(ev0_r & en0_r) | |(ev1_r & en1_r);

    // registered copies of same-clock indications
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            gain_r <= 5'h00;
            lu_r   <= 1'b0;
            fn_r   <= `LSIR_RST_BYTE;
            irq_r  <= 1'b0;
        end else begin
            gain_r <= (line_gain_in > `LSIR_GAIN_TOP) ? `LSIR_GAIN_TOP : line_gain_in;
            lu_r   <= any_ev | line_sub_irq_in;
            fn_r   <= ind_in;
            irq_r  <= any_ev;
        end
    end

    // master clock stand-in at half rate; loss selects it or high
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mclk_tog_r <= 1'b0;
            ref_r      <= 1'b0;
        end else begin
            mclk_tog_r <= ~mclk_tog_r;
            if (los_st) begin
                ref_r <= ref_ctrl_r[`LSIR_BIT_REF_HOLD] ? 1'b1 : ~mclk_tog_r;
            end else begin
                ref_r <= recovered_ref_in;
            end
        end
    end

    assign reference_clock_output = ref_r;
    assign irq                    = irq_r;

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb begin
        rd_mux = 8'h00;
        if (lsir_hit(avs_address, `LSIR_IDX_TX_JIT_CTRL)) rd_mux = jit_ctrl_r[0];
        if (lsir_hit(avs_address, `LSIR_IDX_RX_JIT_CTRL)) rd_mux = jit_ctrl_r[1];
        if (lsir_hit(avs_address, `LSIR_IDX_EV0_ENABLE))  rd_mux = en0_r;
        if (lsir_hit(avs_address, `LSIR_IDX_EV1_ENABLE))  rd_mux = en1_r;
        if (lsir_hit(avs_address, `LSIR_IDX_EDGE_SELECT)) rd_mux = edge_r;
        if (lsir_hit(avs_address, `LSIR_IDX_LINE_STATUS)) rd_mux = {5'h00, df_st, 1'b0, los_st};
        if (lsir_hit(avs_address, `LSIR_IDX_LINE_GAIN))   rd_mux = {3'h0, gain_r};
        if (lsir_hit(avs_address, `LSIR_IDX_TX_JITTER))   rd_mux = {1'b0, jit_val_r[0]};
        if (lsir_hit(avs_address, `LSIR_IDX_RX_JITTER))   rd_mux = {1'b0, jit_val_r[1]};
        if (lsir_hit(avs_address, `LSIR_IDX_LINE_EVENT))  rd_mux = ev0_r;
        if (lsir_hit(avs_address, `LSIR_IDX_ERROR_EVENT)) rd_mux = ev1_r;
        if (lsir_hit(avs_address, `LSIR_IDX_COUNT_HIGH))  rd_mux = zcnt_r[15:8];
        if (lsir_hit(avs_address, `LSIR_IDX_COUNT_LOW))   rd_mux = zcnt_r[7:0];
        if (lsir_hit(avs_address, `LSIR_IDX_REF_CONTROL)) rd_mux = ref_ctrl_r;
        if (lsir_hit(avs_address, `LSIR_IDX_LINE_UNIT))   rd_mux = {7'h00, lu_r};
        if (lsir_hit(avs_address, `LSIR_IDX_FUNCTION))    rd_mux = fn_r;
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence los_rise_s;
        !st_prev_r[0] ##0 st_r[0];
    endsequence

    sequence loss_hold_s;
        los_st && ref_ctrl_r[`LSIR_BIT_REF_HOLD];
    endsequence

    loss_status_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (st_s2_r[0] == st_s3_r[0]) |=> (st_r[0] == $past(st_s3_r[0])))
        else $error("loss status did not follow agreed samples");

    loss_rise_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        los_rise_s |=> ev0_r[`LSIR_BIT_SIG_LOSS])
        else $error("loss rise did not set its event");

    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (clr1[`LSIR_BIT_CODE_VIOL] && !err_in.code_violation) |=> !ev1_r[`LSIR_BIT_CODE_VIOL])
        else $error("write one did not clear flag");

    set_wins_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (err_in.tx_fifo_slip && clr1[`LSIR_BIT_TX_SLIP]) |=> ev1_r[`LSIR_BIT_TX_SLIP])
        else $error("slip event lost");

    jit_clear_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        jit_clr[0] |=> (jit_val_r[0] == 7'h00))
        else $error("jitter clear failed");

    jit_live_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (!jit_ctrl_r[1][`LSIR_BIT_JIT_TEST] && !jit_clr[1]) |=> (jit_val_r[1] == $past(spc[1])))
        else $error("live spacing not shown");

    ref_high_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        loss_hold_s [*2] |=> ref_r)
        else $error("reference output not held high");

    irq_out_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ##1 (irq_r == $past(any_ev)))
        else $error("interrupt does not match enabled flags");

    cnt_wrap_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        zcnt_wrap |=> (zcnt_r == 16'h0000) && ev1_r[`LSIR_BIT_CNT_OVF])
        else $error("counter wrap not flagged");

    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (avs_read || avs_write) |-> ##[0:1] !wait_r)
        else $error("no bus answer within one cycle");

endmodule // lsir_regs

// ---- lsir_regs_tb.sv ----
// self-checking testbench of the line status register group
`timescale 1ns/100ps

module lsir_regs_tb;
    // ****************
    // signals
    // ****************
    logic                      clk;
    logic                      rst_n;
    logic [9:0]                avs_address;
    logic                      avs_read;
    logic                      avs_write;
    logic [31:0]               avs_writedata;
    logic [31:0]               avs_readdata;
    logic                      avs_waitrequest;
    logic                      signal_loss_in;
    logic                      driver_fault_in;
    logic [4:0]                line_gain_in;
    lsir_pkg::lsir_spacing_t   spacing_in;
    lsir_pkg::lsir_err_pulse_t err_in;
    logic                      line_sub_irq_in;
    lsir_pkg::lsir_ind_t       ind_in;
    logic                      recovered_ref_in;
    logic                      reference_clock_output;
    logic                      irq;
    int                        errors;
    int                        n_compared;
    logic [31:0]               rdv;
    logic                      ref_a;
    logic [7:0]                ev_bit [5] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40};
    logic [4:0]                gv [4] = '{5'h00, 5'h14, 5'h15, 5'h1f};

    lsir_regs dut (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .signal_loss_in(signal_loss_in),
        .driver_fault_in(driver_fault_in), .line_gain_in(line_gain_in), .spacing_in(spacing_in),
        .err_in(err_in), .line_sub_irq_in(line_sub_irq_in), .ind_in(ind_in),
        .recovered_ref_in(recovered_ref_in), .reference_clock_output(reference_clock_output), .irq(irq)
    );

    // free-running 250 MHz clock
    initial clk = 1'b0;
    always #2 clk = ~clk;

    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        avs_address   <= {idx, 2'b00};
        avs_read      <= ~wr_en;
        avs_write     <= wr_en;
        avs_writedata <= {24'h000000, wd};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rdv, {24'h000000, exp});
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask

    // pin sampled clear of the edge
    task automatic pin(input logic exp, input logic sel);
        #1;
        chk({31'h0, (sel ? reference_clock_output : irq)}, {31'h0, exp});
    endtask

    task automatic pulse(input logic [4:0] p);
        @(posedge clk);
        err_in <= p;
        @(posedge clk);
        err_in <= 5'h00;
        w(4);
    endtask

    task automatic results;
        if (errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************
    // watchdog
    // ****************
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        results;
    end

    // ****************
    // test sequence
    // ****************
    initial begin
        {rst_n, avs_address, avs_read, avs_write, avs_writedata} = '0;
        {signal_loss_in, driver_fault_in, line_gain_in, spacing_in, err_in} = '0;
        {line_sub_irq_in, ind_in, recovered_ref_in} = '0;
        errors = 0;
        n_compared = 0;
        w(10);
        rst_n <= 1'b1;
        w(3);
        // reset values and an unmapped index
        for (int i = 8'h37; i <= 8'h40; i++) rc(i[7:0], 8'h00);
        rc(8'h50, 8'h00);
        // gain code saturation
        for (int i = 0; i < 4; i++) begin
            line_gain_in <= gv[i];
            w(2);
            rc(8'h37, (gv[i] > 5'h15) ? 8'h15 : {3'h0, gv[i]});
        end
        // function indication bits one at a time
        for (int i = 0; i < 8; i++) begin
            ind_in <= 8'h01 << i;
            w(2);
            rc(8'h40, 8'h01 << i);
        end
        ind_in <= 8'h00;
        line_sub_irq_in <= 1'b1;
        w(2);
        rc(8'h3f, 8'h01);
        line_sub_irq_in <= 1'b0;
        // jitter live spacing, then peak-to-peak and clear per direction
        spacing_in <= {7'h2a, 7'h13};
        w(2);
        rc(8'h38, 8'h2a);
        rc(8'h39, 8'h13);
        for (int d = 0; d < 2; d++) begin
            wr(d ? 8'h27 : 8'h21, 8'h20);
            spacing_in <= {7'h10, 7'h10};
            w(3);
            bus(1'b0, d ? 8'h39 : 8'h38, 8'h00);
            spacing_in <= {7'h18, 7'h18};
            w(2);
            spacing_in <= {7'h12, 7'h12};
            w(2);
            rc(d ? 8'h39 : 8'h38, 8'h08);
            spacing_in <= {7'h14, 7'h14};
            w(2);
            wr(d ? 8'h39 : 8'h38, 8'h01);
            w(2);
            rc(d ? 8'h39 : 8'h38, 8'h00);
            wr(d ? 8'h27 : 8'h21, 8'h00);
        end
        // signal loss status, event, irq and reference output
        wr(8'h33, 8'h05);
        wr(8'h3e, 8'h00);
        signal_loss_in <= 1'b1;
        w(8);
        rc(8'h36, 8'h01);
        rc(8'h3a, 8'h01);
        pin(1'b1, 1'b0);
        rc(8'h3f, 8'h01);
        w(2);
        #1 ref_a = reference_clock_output;
        @(posedge clk);
        pin(~ref_a, 1'b1);
        wr(8'h3e, 8'h01);
        w(3);
        pin(1'b1, 1'b1);
        w(1);
        pin(1'b1, 1'b1);
        wr(8'h3a, 8'h00);
        rc(8'h3a, 8'h01);
        wr(8'h3a, 8'h01);
        rc(8'h3a, 8'h00);
        w(2);
        pin(1'b0, 1'b0);
        @(posedge clk);
        signal_loss_in <= 1'b0;
        w(8);
        rc(8'h3a, 8'h00);
        rc(8'h36, 8'h00);
        recovered_ref_in <= 1'b1;
        w(3);
        pin(1'b1, 1'b1);
        @(posedge clk);
        recovered_ref_in <= 1'b0;
        w(3);
        pin(1'b0, 1'b1);
        // driver fault with both edges selected
        wr(8'h35, 8'h05);
        driver_fault_in <= 1'b1;
        w(8);
        rc(8'h36, 8'h04);
        wr(8'h3a, 8'h04);
        driver_fault_in <= 1'b0;
        w(8);
        rc(8'h3a, 8'h04);
        wr(8'h3a, 8'h04);
        // loss falling edge with both edges selected
        signal_loss_in <= 1'b1;
        w(8);
        wr(8'h3a, 8'h01);
        signal_loss_in <= 1'b0;
        w(8);
        rc(8'h3a, 8'h01);
        wr(8'h3a, 8'h01);
        // each error pulse sets its own flag
        wr(8'h34, 8'h77);
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i);
            rc(8'h3b, ev_bit[i]);
            pin(1'b1, 1'b0);
            wr(8'h3b, ev_bit[i]);
            rc(8'h3b, 8'h00);
        end
        // masked then unmasked interrupt
        wr(8'h34, 8'h00);
        pulse(5'h01);
        pin(1'b0, 1'b0);
        wr(8'h34, 8'h02);
        w(2);
        pin(1'b1, 1'b0);
        wr(8'h3b, 8'h02);
        // clearing write and new slip event in one cycle
        fork
            wr(8'h3b, 8'h20);
            begin
                w(2);
                err_in <= 5'h08;
                @(posedge clk);
                err_in <= 5'h00;
            end
        join
        rc(8'h3b, 8'h20);
        wr(8'h3b, 8'h20);
        // zero-run counter bytes and wrap
        rc(8'h3c, 8'h00);
        rc(8'h3d, 8'h01);
        @(posedge clk);
        err_in <= 5'h02;
        w(65534);
        err_in <= 5'h00;
        w(4);
        rc(8'h3c, 8'hff);
        rc(8'h3d, 8'hff);
        pulse(5'h02);
        rc(8'h3b, 8'h05);
        wr(8'h3b, 8'h00);
        rc(8'h3b, 8'h05);
        rc(8'h3d, 8'h00);
        results;
    end
endmodule // lsir_regs_tb
